//--- core/swmsc_core.sv
// Serial slave, mode control and pin logic of the switch monitor
`timescale 1ns/1ps

module swmsc_core
  import swmsc_pkg::*;
#(
  parameter int unsigned WET_LIMIT  = WET_CYCLES,
  parameter int unsigned POLL_LIMIT = POLL_CYCLES,
  parameter int unsigned ON_LIMIT   = POLL_ON_CYC,
  parameter int unsigned TMR_POLLS  = 8
)
(
  input  wire logic              CLK_SYS_I,
  input  wire logic              RST_I,
  input  wire logic              CS_N_I,
  input  wire logic              SCLK_I,
  input  wire logic              SDI_I,
  input  wire logic              RESET_N_I,
  input  wire logic              ROLE_SELECT_INPUT_I,
  input  wire logic              SYNC_I,
  input  wire logic              INT_N_PIN_I,
  input  wire logic [NUM_SW-1:0] SW_CLOSED_I,
  output logic                   SDO_O,
  output logic                   SDO_OE_O,
  output logic                   INT_N_O,
  output logic                   INT_N_OE_O,
  output logic                   SYNC_O,
  output logic                   SYNC_OE_O,
  output logic                   OSC_EN_O,
  output logic                   SENSE_EN_O,
  output logic [NUM_SW-1:0]      SW_TRISTATE_O,
  output logic [NUM_SW-1:0]      WET_REDUCE_O,
  output logic [NUM_PROG-1:0]    PROG_TO_BAT_O,
  output logic [NUM_SW-1:0]      METALLIC_O,
  output logic                   TEST_MODE_O
);

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  logic cs_n_s;
  logic sclk_s;
  logic sdi_s;
  logic rst_n_s;
  logic sync_s;
  logic role_s;
  logic intp_s;

  swmsc_sync #(.RST_VAL(1'b1)) u_cs   (.clk_i(CLK_SYS_I), .rst_i(RST_I), .pin_i(CS_N_I),
                                       .lvl_o(cs_n_s));
  swmsc_sync #(.RST_VAL(1'b0)) u_sclk (.clk_i(CLK_SYS_I), .rst_i(RST_I), .pin_i(SCLK_I),
                                       .lvl_o(sclk_s));
  swmsc_sync #(.RST_VAL(1'b0)) u_sdi  (.clk_i(CLK_SYS_I), .rst_i(RST_I), .pin_i(SDI_I),
                                       .lvl_o(sdi_s));
  swmsc_sync #(.RST_VAL(1'b0)) u_rstn (.clk_i(CLK_SYS_I), .rst_i(RST_I), .pin_i(RESET_N_I),
                                       .lvl_o(rst_n_s));
  swmsc_sync #(.RST_VAL(1'b0)) u_sync (.clk_i(CLK_SYS_I), .rst_i(RST_I), .pin_i(SYNC_I),
                                       .lvl_o(sync_s));
  swmsc_sync #(.RST_VAL(1'b0)) u_role (.clk_i(CLK_SYS_I), .rst_i(RST_I),
                                       .pin_i(ROLE_SELECT_INPUT_I), .lvl_o(role_s));
  swmsc_sync #(.RST_VAL(1'b1)) u_intp (.clk_i(CLK_SYS_I), .rst_i(RST_I), .pin_i(INT_N_PIN_I),
                                       .lvl_o(intp_s));

  logic [NUM_SW-1:0] sw_m1_r;
  logic [NUM_SW-1:0] sw_m2_r;
  logic [NUM_SW-1:0] sw_m3_r;
  logic [NUM_SW-1:0] sw_s_r;

  // Switch comparator outputs, three stages, agree filter
  always_ff @(posedge CLK_SYS_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      sw_m1_r <= '0;
      sw_m2_r <= '0;
      sw_m3_r <= '0;
      sw_s_r  <= '0;
    end
    else
    begin
      sw_m1_r <= SW_CLOSED_I;
      sw_m2_r <= sw_m1_r;
      sw_m3_r <= sw_m2_r;
      sw_s_r  <= (sw_m2_r & sw_m3_r) | (sw_s_r & (sw_m2_r | sw_m3_r));
    end
  end

  // ==========================================================================
  // Edge detection
  // ==========================================================================
  logic cs_d_r;
  logic sclk_d_r;
  logic sync_d_r;

  always_ff @(posedge CLK_SYS_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      cs_d_r   <= 1'b1;
      sclk_d_r <= 1'b0;
      sync_d_r <= 1'b0;
    end
    else
    begin
      cs_d_r   <= cs_n_s;
      sclk_d_r <= sclk_s;
      sync_d_r <= sync_s;
    end
  end

  wire cs_fall   = cs_d_r && !cs_n_s;
  wire cs_rise   = !cs_d_r && cs_n_s;
  wire selected  = !cs_n_s && !cs_d_r;
  wire sclk_rise = selected && sclk_s && !sclk_d_r;
  wire sclk_fall = selected && !sclk_s && sclk_d_r;
  wire sync_rise = sync_s && !sync_d_r;
  wire hw_reset  = !rst_n_s;

  // ==========================================================================
  // Mode state
  // ==========================================================================
  swmsc_mode_t mode_r;
  swmsc_mode_t mode_nxt;
  logic [15:0] cmd_r;
  logic [11:0] tri_r;
  logic [11:0] met_r;
  logic [3:0]  cp_r;
  logic        test_r;

  logic [15:0] shin_r;
  logic [15:0] shout_r;
  logic [5:0]  bitcnt_r;

  wire [3:0] opc       = shin_r[OPC_MSB:OPC_LSB];
  wire       len_ok    = (bitcnt_r == BITS_SINGLE) || (bitcnt_r == BITS_CHAINED);
  wire       apply     = cs_rise && len_ok;
  wire       is_sleep  = apply && (opc == OPC_SLEEP);
  wire       is_run    = apply && (opc == OPC_RUN);
  wire       is_tri    = apply && (opc == OPC_TRISTATE);
  wire       is_met    = apply && (opc == OPC_METALLIC);
  wire       is_test   = apply && opc[3];
  wire [1:0] run_mod   = shin_r[RUN_MOD_MSB:RUN_MOD_LSB];
  wire       polling   = (mode_r == SWMSC_POLL) || (mode_r == SWMSC_POLLTMR);

  // Poll sequencing signals
  logic        poll_on_r;
  logic        closed_seen;
  logic        tmr_expire;

  always_comb
  begin
    mode_nxt = mode_r;
    if (is_sleep)
      mode_nxt = SWMSC_SLEEP;
    else if (is_run)
      mode_nxt = (run_mod == MODE_POLL)    ? SWMSC_POLL :
                 (run_mod == MODE_POLLTMR) ? SWMSC_POLLTMR : SWMSC_NORMAL;
    // tri-state and metallic also wake from sleep
    else if ((is_tri || is_met) && (mode_r == SWMSC_SLEEP))
      mode_nxt = SWMSC_NORMAL;
    else if (polling && poll_on_r && closed_seen)
      mode_nxt = SWMSC_NORMAL;
  end

  // reset pin forces sleep and clears state
  always_ff @(posedge CLK_SYS_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      mode_r <= SWMSC_SLEEP;
      cmd_r  <= CMD_RST;
      tri_r  <= TRI_RST;
      met_r  <= '0;
      cp_r   <= '0;
      test_r <= 1'b0;
    end
    else if (hw_reset)
    begin
      mode_r <= SWMSC_SLEEP;
      cmd_r  <= CMD_RST;
      tri_r  <= TRI_RST;
      met_r  <= '0;
      cp_r   <= '0;
      test_r <= 1'b0;
    end
    else
    begin
      // command takes effect at select rise
      mode_r <= mode_nxt;
      if (is_sleep || is_run || is_tri || is_met || is_test)
        cmd_r <= shin_r;
      if (is_tri)
        tri_r <= shin_r[11:0];
      if (is_met)
        met_r <= shin_r[11:0];
      if (is_run)
        cp_r <= shin_r[RUN_CP_MSB:RUN_CP_LSB];
      if (is_test)
        test_r <= 1'b1;
      else if (is_sleep || is_run || is_tri || is_met)
        test_r <= 1'b0;
    end
  end

  // ==========================================================================
  // Shift registers
  // ==========================================================================
  wire [1:0] mode_code = (mode_r == SWMSC_SLEEP)   ? MODE_SLEEP :
                         (mode_r == SWMSC_POLL)    ? MODE_POLL :
                         (mode_r == SWMSC_POLLTMR) ? MODE_POLLTMR : MODE_NORMAL;
  // closed is 1; tri-stated inputs report 0
  wire [NUM_SW-1:0] sw_rpt = (mode_r == SWMSC_SLEEP) ? '0 : (sw_s_r & ~tri_r);
  // flag is inverse of interrupt pin
  wire [15:0] rsp_word = {!intp_s, role_s, mode_code, sw_rpt};

  always_ff @(posedge CLK_SYS_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      shin_r   <= '0;
      shout_r  <= '0;
      bitcnt_r <= '0;
    end
    else if (cs_fall)
    begin
      shout_r  <= rsp_word;
      bitcnt_r <= '0;
    end
    else
    begin
      if (sclk_rise)
      begin
        shin_r   <= {shin_r[14:0], sdi_s};
        bitcnt_r <= (&bitcnt_r) ? bitcnt_r : bitcnt_r + 6'h01;
      end
      // advance on falling clock, chained data follows
      if (sclk_fall)
        shout_r <= {shout_r[14:0], shin_r[0]};
    end
  end

  // ==========================================================================
  // Serial output driver
  // ==========================================================================
  // MSB appears as soon as select falls
  always_ff @(posedge CLK_SYS_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      SDO_O    <= 1'b0;
      SDO_OE_O <= 1'b0;
    end
    else
    begin
      SDO_OE_O <= !cs_n_s;
      SDO_O    <= cs_fall ? rsp_word[15] : (sclk_fall ? shout_r[14] : SDO_O);
    end
  end

  // ==========================================================================
  // Polling oscillator and sequencer
  // ==========================================================================
  localparam int unsigned PW = $clog2(POLL_LIMIT + 1);
  localparam int unsigned OW = $clog2(ON_LIMIT + 1);
  localparam int unsigned TW = $clog2(TMR_POLLS + 1);

  logic [PW-1:0] per_r;
  logic [OW-1:0] on_r;
  logic [TW-1:0] polls_r;
  logic          sync_r;

  wire master    = role_s;
  // master runs oscillator, slave halts it between polls while polling
  wire osc_run   = !polling || master || poll_on_r;
  wire per_done  = (per_r == PW'(POLL_LIMIT - 1));
  // master starts polls; slave starts on sync
  wire poll_go   = polling && !poll_on_r && (master ? per_done : sync_rise);
  wire on_done   = (on_r == OW'(ON_LIMIT - 1));
  assign closed_seen = |sw_rpt;
  assign tmr_expire  = (mode_r == SWMSC_POLLTMR) && poll_on_r && on_done
                       && (polls_r == TW'(TMR_POLLS - 1));

  always_ff @(posedge CLK_SYS_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      per_r     <= '0;
      on_r      <= '0;
      polls_r   <= '0;
      poll_on_r <= 1'b0;
      sync_r    <= 1'b0;
    end
    else if (hw_reset || !polling)
    begin
      per_r     <= '0;
      on_r      <= '0;
      polls_r   <= '0;
      poll_on_r <= 1'b0;
      sync_r    <= 1'b0;
    end
    else
    begin
      per_r  <= (master && !poll_on_r && !per_done) ? per_r + PW'(1) : '0;
      sync_r <= master && poll_go;
      if (poll_go)
        poll_on_r <= 1'b1;
      else if (poll_on_r && on_done)
        poll_on_r <= 1'b0;
      on_r <= (poll_on_r && !on_done) ? on_r + OW'(1) : '0;
      if (tmr_expire)
        polls_r <= '0;
      else if (poll_on_r && on_done)
        polls_r <= polls_r + TW'(1);
    end
  end

  // ==========================================================================
  // Interrupt output
  // ==========================================================================
  logic [NUM_SW-1:0] sw_prev_r;
  logic              int_r;

  wire chg_evt  = (mode_r == SWMSC_NORMAL) && (sw_rpt != sw_prev_r);
  // polling interrupts only while currents on
  wire poll_evt = polling && poll_on_r && (closed_seen || tmr_expire);

  always_ff @(posedge CLK_SYS_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      sw_prev_r <= '0;
      int_r     <= 1'b0;
    end
    else
    begin
      sw_prev_r <= sw_rpt;
      // select rise releases, new event wins
      if (hw_reset)
        int_r <= 1'b0;
      else if (chg_evt || poll_evt)
        int_r <= 1'b1;
      else if (cs_rise)
        int_r <= 1'b0;
    end
  end

  // ==========================================================================
  // Pin and analog control outputs
  // ==========================================================================
  genvar gi;
  logic [NUM_SW-1:0] wet_red;
  generate
    for (gi = 0; gi < NUM_SW; gi++)
    begin : g_wet
      swmsc_timer #(.LIMIT(WET_LIMIT)) u_tmr (
        .clk_i    (CLK_SYS_I),
        .rst_i    (RST_I),
        .closed_i (sw_s_r[gi] && !hw_reset),
        .reduce_o (wet_red[gi])
      );
    end
  endgenerate

  wire sleeping = (mode_r == SWMSC_SLEEP);

  always_ff @(posedge CLK_SYS_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      INT_N_O       <= 1'b0;
      INT_N_OE_O    <= 1'b0;
      SYNC_O        <= 1'b0;
      SYNC_OE_O     <= 1'b0;
      OSC_EN_O      <= 1'b1;
      SENSE_EN_O    <= 1'b0;
      SW_TRISTATE_O <= '1;
      WET_REDUCE_O  <= '0;
      PROG_TO_BAT_O <= '0;
      METALLIC_O    <= '0;
      TEST_MODE_O   <= 1'b0;
    end
    else
    begin
      INT_N_O       <= 1'b0;             // Open drain: drive low only
      INT_N_OE_O    <= int_r;
      SYNC_O        <= sync_r;
      SYNC_OE_O     <= master && polling;
      OSC_EN_O      <= osc_run;
      SENSE_EN_O    <= !sleeping && (!polling || poll_on_r);
      SW_TRISTATE_O <= sleeping ? '1 : tri_r;
      WET_REDUCE_O  <= wet_red;
      PROG_TO_BAT_O <= cp_r;
      METALLIC_O    <= met_r;
      TEST_MODE_O   <= test_r;
    end
  end

endmodule

//--- core/swmsc_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module swmsc_sync
  import swmsc_pkg::*;
#(
  parameter logic RST_VAL = 1'b0
)
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic pin_i,
  output logic      lvl_o
);

  logic s1_r;
  logic s2_r;
  logic s3_r;

  // ==========================================================================
  // Synchroniser chain
  // ==========================================================================
  // Stage one feeds stage two only
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s1_r  <= RST_VAL;
      s2_r  <= RST_VAL;
      s3_r  <= RST_VAL;
      lvl_o <= RST_VAL;
    end
    else
    begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r)
        lvl_o <= s3_r;  // Change counts once two stages agree
    end
  end

endmodule

//--- core/swmsc_timer.sv
// Per-switch closure timer that lowers the wetting current
`timescale 1ns/1ps
module swmsc_timer
  import swmsc_pkg::*;
#(
  parameter int unsigned LIMIT = WET_CYCLES
)
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic closed_i,
  output logic      reduce_o
);

  localparam int unsigned TW = $clog2(LIMIT + 1);

  logic [TW-1:0] cnt_r;
  wire           done = (cnt_r == TW'(LIMIT));

  // ==========================================================================
  // Closure time counter
  // ==========================================================================
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt_r    <= '0;
      reduce_o <= 1'b0;
    end
    else
    begin
      if (!closed_i)
        cnt_r <= '0;
      else if (!done)
        cnt_r <= cnt_r + TW'(1);
      reduce_o <= closed_i && done;
    end
  end

endmodule

//--- include/swmsc_pkg.sv
// Package: constants and types shared by the switch monitor serial control block
package swmsc_pkg;

  // ==========================================================================
  // Word layout
  // ==========================================================================
  localparam int unsigned WORD_W       = 16;
  localparam int unsigned CNT_W        = 6;
  localparam logic [5:0]  BITS_SINGLE  = 6'h10;
  localparam logic [5:0]  BITS_CHAINED = 6'h20;
  localparam int unsigned NUM_SW       = 12;
  localparam int unsigned NUM_PROG     = 4;
  localparam int unsigned OPC_MSB      = 15;
  localparam int unsigned OPC_LSB      = 12;

  // Response word fields
  localparam int unsigned RSP_INT_BIT  = 15;
  localparam int unsigned RSP_ROLE_BIT = 14;
  localparam int unsigned RSP_MODE_MSB = 13;
  localparam int unsigned RSP_MODE_LSB = 12;

  // Run command fields
  localparam int unsigned RUN_MOD_MSB  = 11;
  localparam int unsigned RUN_MOD_LSB  = 10;
  localparam int unsigned RUN_CP_MSB   = 3;
  localparam int unsigned RUN_CP_LSB   = 0;

  // Command opcodes in the top four bits
  localparam logic [3:0] OPC_SLEEP    = 4'h0;
  localparam logic [3:0] OPC_RUN      = 4'h1;
  localparam logic [3:0] OPC_TRISTATE = 4'h3;
  localparam logic [3:0] OPC_METALLIC = 4'h5;

  // Reset values
  localparam logic [15:0] CMD_RST      = 16'h0000;
  localparam logic [11:0] TRI_RST      = 12'h000;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned CLK_HZ       = 40_000_000;
  localparam int unsigned WET_TIME_MS  = 20;
  localparam int unsigned WET_CYCLES   = CLK_HZ / 1000 * WET_TIME_MS;
  localparam int unsigned POLL_TIME_MS = 40;
  localparam int unsigned POLL_CYCLES  = CLK_HZ / 1000 * POLL_TIME_MS;
  localparam int unsigned POLL_ON_US   = 100;
  localparam int unsigned POLL_ON_CYC  = CLK_HZ / 1_000_000 * POLL_ON_US;

  // Operating modes
  typedef enum logic [3:0] {
    SWMSC_SLEEP   = 4'b0001,
    SWMSC_NORMAL  = 4'b0010,
    SWMSC_POLL    = 4'b0100,
    SWMSC_POLLTMR = 4'b1000
  } swmsc_mode_t;

  // Mode field codes
  localparam logic [1:0] MODE_NORMAL  = 2'h0;
  localparam logic [1:0] MODE_POLL    = 2'h1;
  localparam logic [1:0] MODE_POLLTMR = 2'h2;
  localparam logic [1:0] MODE_SLEEP   = 2'h3;

endpackage

//--- verification/swmsc_core_tb.sv
// Testbench: runs the switch monitor serial block through its host model
`timescale 1ns/1ps
module swmsc_core_tb
  import swmsc_pkg::*;
;
  logic                clk, rst, rst_n, role, sync_in, int_pin;
  logic                cs_n, sclk, sdi, sdo, sdo_oe, int_n, int_oe;
  logic                sync_o, sync_oe, sense_en, osc_en, test, sdo_line;
  logic [NUM_SW-1:0]   sw, trist, wet, metal;
  logic [NUM_PROG-1:0] prog;
  logic [31:0]         rx;
  logic [3:0]          bad [4] = '{4'h2, 4'h4, 4'h6, 4'h7};
  int                  err_total, check_count, cyc;

  swmsc_core #(.WET_LIMIT(20), .POLL_LIMIT(50), .ON_LIMIT(8), .TMR_POLLS(3)) dut
  (
    .CLK_SYS_I          (clk),
    .RST_I              (rst),
    .CS_N_I             (cs_n),
    .SCLK_I             (sclk),
    .SDI_I              (sdi),
    .RESET_N_I          (rst_n),
    .ROLE_SELECT_INPUT_I(role),
    .SYNC_I             (sync_in),
    .INT_N_PIN_I        (int_pin),
    .SW_CLOSED_I        (sw),
    .SDO_O              (sdo),
    .SDO_OE_O           (sdo_oe),
    .INT_N_O            (int_n),
    .INT_N_OE_O         (int_oe),
    .SYNC_O             (sync_o),
    .SYNC_OE_O          (sync_oe),
    .OSC_EN_O           (osc_en),
    .SENSE_EN_O         (sense_en),
    .SW_TRISTATE_O      (trist),
    .WET_REDUCE_O       (wet),
    .PROG_TO_BAT_O      (prog),
    .METALLIC_O         (metal),
    .TEST_MODE_O        (test)
  );

  swmsc_host host
  (
    .clk_i (clk),
    .sdo_i (sdo_line),
    .cs_n_o(cs_n),
    .sclk_o(sclk),
    .sdi_o (sdi)
  );

  // Wired interrupt line with pull-up
  assign int_pin = int_oe ? int_n : 1'h1;

  // Released serial output shows the inverse of its last bit
  assign sdo_line = sdo_oe ? sdo : !sdo;

  // ==========================================================================
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic sx(input int n, input logic [31:0] tx);
    host.xfer(n, tx, rx);
  endtask

  function automatic logic probe(input int k);
    case (k)
      0: return sync_o;
      1: return !osc_en;
      2: return osc_en;
      3: return int_oe;
      default: return !int_oe;
    endcase
  endfunction

  // Bounded wait for a condition, then judge it
  task automatic await(input int k, input int lim);
    int i;
    i = 0;
    while (probe(k) !== 1'h1 && i < lim)
    begin
      @(posedge clk);
      i++;
    end
    chk(probe(k), 1'h1);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ==========================================================================
  // Clock and hang guard
  initial
  begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_total++;
      finish_test();
    end
  end

  // ==========================================================================
  // Scenarios
  initial
  begin
    rst = 1'h1;
    {rst_n, role, sync_in, sw} = {3'h6, 12'h000};
    {err_total, check_count, cyc} = '0;
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    repeat (8) @(posedge clk);
    chk(trist, 12'hfff);
    chk({sdo_oe, int_oe, osc_en}, 3'h1);
    chk(sense_en, 1'h0);
    sx(16, {OPC_RUN, MODE_NORMAL, 6'h00, 4'ha});
    chk(rx, 32'h7000);
    chk({prog, trist}, 16'ha000);
    chk({sense_en, sync_oe}, 2'h2);
    $display("test reset done");
    sw <= 12'ha5c;
    await(3, 20);
    sx(16, {OPC_RUN, MODE_NORMAL, 6'h00, 4'ha});
    chk(rx, 32'hca5c);
    await(4, 10);
    chk(wet, 12'ha5c);
    sx(15, 32'h0);
    sx(16, {OPC_RUN, MODE_NORMAL, 6'h00, 4'ha});
    chk(rx, 32'h4a5c);
    foreach (bad[j]) sx(16, {bad[j], 12'hfff});
    chk({prog, trist, metal}, 28'ha000000);
    sx(32, {16'hc3a5, OPC_RUN, MODE_NORMAL, 6'h00, 4'h5});
    chk(rx, 32'h4a5cc3a5);
    chk(prog, 4'h5);
    sx(16, {OPC_TRISTATE, 12'h00f});
    chk(trist, 12'h00f);
    sx(16, {OPC_METALLIC, 12'h0f0});
    chk(rx[14:0], 15'h4a50);
    chk(metal, 12'h0f0);
    sx(16, 16'h8000);
    chk(test, 1'h1);
    $display("test commands done");
    rst_n <= 1'h0;
    repeat (12) @(posedge clk);
    chk({trist, test, prog, metal}, 29'h1ffe0000);
    rst_n <= 1'h1;
    repeat (12) @(posedge clk);
    sx(16, {OPC_SLEEP, 12'h000});
    chk(rx, 32'h7000);
    sw <= 12'h000;
    $display("test device reset done");
    sx(16, {OPC_RUN, MODE_POLL, 6'h00, 4'h0});
    await(0, 150);
    chk(sync_oe, 1'h1);
    role <= 1'h0;
    await(1, 200);
    chk({sync_oe, sense_en}, 2'h0);
    sync_in <= 1'h1;
    repeat (2) @(posedge clk);
    sync_in <= 1'h0;
    await(2, 20);
    role <= 1'h1;
    repeat (8) @(posedge clk);
    sx(16, {OPC_RUN, MODE_POLLTMR, 6'h00, 4'h0});
    chk(rx, 32'h5000);
    await(3, 600);
    sx(16, {OPC_SLEEP, 12'h000});
    chk(rx, 32'he000);
    $display("test polling done");
    finish_test();
  end
endmodule

//--- verification/swmsc_host.sv
// Host model: serial bus master driving select, clock and data
`timescale 1ns/1ps
module swmsc_host
(
  input  wire logic clk_i,
  input  wire logic sdo_i,
  output logic      cs_n_o,
  output logic      sclk_o,
  output logic      sdi_o
);
  initial
  begin
    cs_n_o = 1'h1;
    sclk_o = 1'h0;
    sdi_o  = 1'h0;
  end

  // Let n system clocks pass
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // whole frame, select moved with clock low
  task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
    rx = 32'h0;
    cs_n_o <= 1'h0;
    for (int i = n - 1; i >= 0; i--)
    begin
      sdi_o <= tx[i];
      tick(4);
      sclk_o <= 1'h1;
      tick(4);
      rx[i] = sdo_i;
      sclk_o <= 1'h0;
    end
    tick(4);
    cs_n_o <= 1'h1;
    sdi_o  <= ~sdi_o; // Released line shows inverse
    tick(12);
  endtask
endmodule

//--- verification/swmsc_props.sv
// Checker: port properties of the switch monitor serial block
`timescale 1ns/1ps
module swmsc_props
  import swmsc_pkg::*;
(
  input wire logic              CLK_SYS_I,
  input wire logic              RST_I,
  input wire logic              CS_N_I,
  input wire logic              RESET_N_I,
  input wire logic              ROLE_SELECT_INPUT_I,
  input wire logic [NUM_SW-1:0] SW_CLOSED_I,
  input wire logic              SDO_OE_O,
  input wire logic              INT_N_OE_O,
  input wire logic              SYNC_O,
  input wire logic              SYNC_OE_O,
  input wire logic              SENSE_EN_O,
  input wire logic [NUM_SW-1:0] SW_TRISTATE_O,
  input wire logic [NUM_SW-1:0] WET_REDUCE_O
);
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (RST_I);

  // ==========================================================================
  // Frame and reset steps
  sequence s_sel;
    $fell(CS_N_I);
  endsequence
  sequence s_desel;
    $rose(CS_N_I);
  endsequence
  sequence s_held;
    !RESET_N_I [*8];
  endsequence

  // ==========================================================================
  // Properties
  chk_oe_idle: assert property (CS_N_I [*8] |-> !SDO_OE_O)
    else $error("serial out enabled while deselected");
  chk_oe_on: assert property (s_sel |-> ##[3:8] SDO_OE_O)
    else $error("serial out not enabled after select");
  chk_oe_off: assert property (s_desel |-> ##[3:8] !SDO_OE_O)
    else $error("serial out not released after deselect");
  chk_rst_int: assert property (s_held |-> !INT_N_OE_O)
    else $error("interrupt held during device reset");
  chk_rst_pins: assert property (s_held |-> &SW_TRISTATE_O && !SENSE_EN_O)
    else $error("inputs active during device reset");
  chk_sync_one: assert property ($rose(SYNC_O) |-> SYNC_OE_O ##1 !SYNC_O)
    else $error("sync pulse malformed");
  chk_slave_mute: assert property (!ROLE_SELECT_INPUT_I [*8] |-> !SYNC_OE_O)
    else $error("slave drives sync");
  chk_wet_wait: assert property ($rose(SW_CLOSED_I[2]) |-> !WET_REDUCE_O[2] [*8])
    else $error("wetting current lowered too early");
  chk_int_sense: assert property ($rose(INT_N_OE_O) |-> $past(SENSE_EN_O))
    else $error("interrupt raised while sense currents off");
endmodule

bind swmsc_core swmsc_props u_props
(
  .CLK_SYS_I,
  .RST_I,
  .CS_N_I,
  .RESET_N_I,
  .ROLE_SELECT_INPUT_I,
  .SW_CLOSED_I,
  .SDO_OE_O,
  .INT_N_OE_O,
  .SYNC_O,
  .SYNC_OE_O,
  .SENSE_EN_O,
  .SW_TRISTATE_O,
  .WET_REDUCE_O
);
